// ---- rtl/alert_pkg.sv ----
/*
 * constants shared by the alert, reset and address logic: register offsets,
 * field positions, reset values, sleep codes and timing counts.
 * assumes a 100 MHz system clock and 32-bit AXI4-Lite register access.
 */
package alert_pkg;
	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESP_TIME_NS = 10000; // longest response to reset or overheat
	localparam int RESP_CYCLES = RESP_TIME_NS / CLK_PERIOD_NS;
	localparam int MIN_PULSE_NS = 4000; // shortest external reset pulse
	localparam int MIN_PULSE_CYCLES = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_TIME_NS = 2000; // reset pin driven low after power-up
	localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_SETTLE_CYCLES = 4; // pull-up and synchroniser settle
	localparam int RAMP_TIME_NS = 10000; // one step of the fan boost ramp
	localparam int RAMP_CYCLES = RAMP_TIME_NS / CLK_PERIOD_NS;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] CONFIG_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] ERROR_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS = 8'h0C;
	localparam logic [7:0] GPIO_OFS = 8'h10;
	localparam logic [7:0] FAN_OFS = 8'h14;
	// ==========================================================
	// configuration fields
	localparam int CFG_ALERT_EN = 0;
	localparam int CFG_LOCK = 1;
	localparam int CFG_THR_DIS = 2;
	localparam int CFG_SLEEP_LO = 4;
	localparam int CFG_SLEEP_HI = 5;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	// ==========================================================
	// error status fields: [1:0] overheat, [11:2] general inputs,
	// [13:12] thermal (comparator), [15:14] fixed throttle thresholds
	localparam int ERR_HOT_LO = 0;
	localparam int ERR_GP_LO = 2;
	localparam int ERR_THERM_LO = 12;
	localparam int ERR_FIXED_LO = 14;
	localparam int ERR_WIDTH = 16;
	localparam logic [15:0] ERR_ALERT_MASK = 16'h3FFF; // fixed threshold bits excluded
	localparam logic [11:0] MASK_RESET = 12'h000;
	// ==========================================================
	// sleep state codes
	localparam logic [1:0] SLEEP_S0 = 2'h0;
	localparam logic [1:0] SLEEP_S3 = 2'h1;
	localparam logic [1:0] SLEEP_S45 = 2'h2;
	// ==========================================================
	// slave address: fixed upper five bits, select level codes
	localparam logic [4:0] ADDR_UPPER = 5'h0B;
	localparam logic [1:0] SEL_LOW = 2'h0;
	localparam logic [1:0] SEL_MID = 2'h1;
	localparam logic [1:0] SEL_HIGH = 2'h2;
	localparam logic [1:0] LOW_BITS_HIGH = 2'h1;
	localparam logic [1:0] LOW_BITS_MID = 2'h2;
	localparam logic [1:0] LOW_BITS_LOW = 2'h0;
	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/alert_reset_address_logic.sv ----
/*
 * alert, reset pin, overheat, general input and slave address logic of a
 * hardware monitor, with an AXI4-Lite register slave.
 * assumes synchronous inputs apart from the pins passed through synchronisers;
 * the testbench resolves open-drain wires from the output enables.
 */
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module alert_reset_address_logic #(
	parameter int POR_LEN = alert_pkg::POR_CYCLES,
	parameter int RAMP_LEN = alert_pkg::RAMP_CYCLES
) (
	// clock and power-on reset
	input wire logic mclk,
	input wire logic rst,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// alert pin, open drain
	output logic alert_n_out,
	output logic alert_n_oe,
	// reset pin, two-way open drain
	input wire logic reset_n_in,
	output logic reset_n_out,
	output logic reset_n_oe,
	// regulator overheat inputs and throttle lines
	input wire logic regulator1_overheat_in,
	input wire logic regulator2_overheat_in,
	output logic [1:0] processor_throttle_line_out,
	output logic [1:0] processor_throttle_line_oe,
	// thermal error events and zone temperature
	input wire logic [1:0] thermal_event,
	input wire logic [7:0] zone_temp,
	output logic fan_drive_1,
	output logic fan_drive_2,
	// general purpose pins
	input wire logic [7:0] gpio_in,
	output logic [7:0] gpio_out,
	output logic [7:0] gpio_oe,
	input wire logic [1:0] input_only_pin,
	// slave address from the serial interface
	input wire logic [alert_pkg::SEL_HIGH:0] addr_sel,
	input wire logic txn_valid,
	input wire logic [6:0] txn_addr,
	output logic [6:0] slave_addr,
	output logic addr_latched,
	output logic addr_hit
);
	import alert_pkg::*;

	// ==========================================================
	// input synchronisers
	localparam int SYNC_W = 13;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [1:0] hot_s;
	logic [9:0] gp_s;
	logic reset_s;

	// two stages; only the second stage is read
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_reg <= {SYNC_W{1'b1}} & 13'h1000;
			sync2_reg <= 13'h1000;
		end else begin
			sync1_reg <= {reset_n_in, input_only_pin, gpio_in,
				regulator2_overheat_in, regulator1_overheat_in};
			sync2_reg <= sync1_reg;
		end
	end
	assign hot_s = sync2_reg[1:0];
	assign gp_s = sync2_reg[11:2];
	assign reset_s = sync2_reg[12];

	// ==========================================================
	// power-on reset drive of the reset pin
	logic [15:0] por_cnt_reg;
	logic ext_armed;
	logic ext_reset;

	// count the drive window, then settle, then arm detection
	always_ff @(posedge mclk) begin
		if (rst) begin
			por_cnt_reg <= 16'h0000;
		end else if (32'(por_cnt_reg) < POR_LEN + POR_SETTLE_CYCLES) begin
			por_cnt_reg <= por_cnt_reg + 16'h0001;
		end
	end
	assign ext_armed = 32'(por_cnt_reg) >= POR_LEN + POR_SETTLE_CYCLES;
	// held low is detected every cycle; pulses over 4 us are far longer than the path
	assign ext_reset = ext_armed && !reset_s;

	// pin driven low during the window, released afterwards
	always_ff @(posedge mclk) begin
		if (rst) begin
			reset_n_oe <= 1'b1;
			reset_n_out <= 1'b0;
		end else begin
			reset_n_oe <= 32'(por_cnt_reg) + 1 < POR_LEN;
			reset_n_out <= 1'b0;
		end
	end

	// ==========================================================
	// register bus write path
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_go;
	logic [31:0] config_reg;
	logic [ERR_WIDTH-1:0] err_reg;
	logic [11:0] mask_reg;
	logic [15:0] gpio_ctl_reg;
	logic [7:0] fan_base_reg;

	// applies byte strobes to an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// true for a mapped register offset
	function automatic logic mapped(input logic [7:0] a);
		return a == CONFIG_OFS || a == STATUS_OFS || a == ERROR_OFS || a == MASK_OFS
			|| a == GPIO_OFS || a == FAN_OFS;
	endfunction

	assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

	// address and data taken in either order, answer after both
	always_ff @(posedge mclk) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			// ready only while that channel is free and no answer will stand
			s_axi_awready <= !wr_go && !aw_held_reg && !(s_axi_awvalid && s_axi_awready)
				&& !(s_axi_bvalid && !s_axi_bready);
			s_axi_wready <= !wr_go && !w_held_reg && !(s_axi_wvalid && s_axi_wready)
				&& !(s_axi_bvalid && !s_axi_bready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				waddr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// configuration: alert enable, lock, throttle disable, sleep state
	logic [31:0] cfg_wr;
	assign cfg_wr = merge(config_reg, wdata_reg, wstrb_reg);

	always_ff @(posedge mclk) begin
		if (rst) begin
			config_reg <= CONFIG_RESET;
		end else begin
			if (wr_go && waddr_reg == CONFIG_OFS) begin
				config_reg[CFG_ALERT_EN] <= cfg_wr[CFG_ALERT_EN];
				config_reg[CFG_THR_DIS] <= cfg_wr[CFG_THR_DIS];
				config_reg[CFG_SLEEP_HI:CFG_SLEEP_LO] <= cfg_wr[CFG_SLEEP_HI:CFG_SLEEP_LO];
				config_reg[CFG_LOCK] <= config_reg[CFG_LOCK] | cfg_wr[CFG_LOCK];
			end
			if (ext_reset) begin
				config_reg[CFG_LOCK] <= 1'b0;
				config_reg[CFG_SLEEP_HI:CFG_SLEEP_LO] <= SLEEP_S45;
			end
		end
	end

	// mask, gpio control and fan base; mask frozen while locked
	always_ff @(posedge mclk) begin
		if (rst) begin
			mask_reg <= MASK_RESET;
			gpio_ctl_reg <= 16'h0000;
			fan_base_reg <= 8'h00;
		end else if (wr_go) begin
			if (waddr_reg == MASK_OFS && !config_reg[CFG_LOCK]) begin
				mask_reg <= 12'(merge({20'h00000, mask_reg}, wdata_reg, wstrb_reg));
			end
			if (waddr_reg == GPIO_OFS) begin
				gpio_ctl_reg <= 16'(merge({16'h0000, gpio_ctl_reg}, wdata_reg, wstrb_reg));
			end
			if (waddr_reg == FAN_OFS) begin
				fan_base_reg <= 8'(merge({24'h000000, fan_base_reg}, wdata_reg, wstrb_reg));
			end
		end
	end

	// ==========================================================
	// error status: sticky events, write one to clear, set wins
	logic awake;
	logic [9:0] gp_event;
	logic [ERR_WIDTH-1:0] err_set;
	logic [ERR_WIDTH-1:0] err_clr;
	logic [ERR_WIDTH-1:0] err_view;
	logic summary;

	assign awake = config_reg[CFG_SLEEP_HI:CFG_SLEEP_LO] == SLEEP_S0;
	// inputs only, unmasked; bidirectional pins count only while not driven
	assign gp_event = gp_s & ~mask_reg[9:0] & {2'b11, ~gpio_ctl_reg[15:8]};
	assign err_set = {2'b00, 2'b00, gp_event, hot_s & {2{awake}}};
	assign err_clr = (wr_go && waddr_reg == ERROR_OFS)
		? ERR_WIDTH'(merge(32'h0000_0000, wdata_reg, wstrb_reg)) : '0;

	always_ff @(posedge mclk) begin
		if (rst) begin
			err_reg <= '0;
		end else begin
			err_reg <= (err_reg & ~err_clr) | err_set;
		end
	end
	// thermal bits follow the live unmasked event
	assign err_view = {err_reg[15:14], thermal_event & ~mask_reg[11:10], err_reg[11:0]};
	assign summary = |(err_view & ERR_ALERT_MASK);

	// ==========================================================
	// alert pin and summary flag
	logic error_summary_flag;

	// summary always updated; pin pulled only when enabled
	always_ff @(posedge mclk) begin
		if (rst) begin
			error_summary_flag <= 1'b0;
			alert_n_oe <= 1'b0;
			alert_n_out <= 1'b0;
		end else begin
			error_summary_flag <= summary;
			alert_n_oe <= config_reg[CFG_ALERT_EN] && summary;
			alert_n_out <= 1'b0;
		end
	end

	// ==========================================================
	// throttle lines and fan drive
	logic [7:0] boost_reg [2];
	logic [15:0] ramp_cnt_reg;
	logic [7:0] pwm_cnt_reg;
	logic [7:0] duty [2];

	// throttle follows overheat while awake and not disabled
	always_ff @(posedge mclk) begin
		if (rst) begin
			processor_throttle_line_oe <= 2'b00;
			processor_throttle_line_out <= 2'b00;
		end else begin
			processor_throttle_line_oe <= hot_s & {2{awake && !config_reg[CFG_THR_DIS]}};
			processor_throttle_line_out <= 2'b00;
		end
	end

	// boost climbs one step per ramp period while hot, falls when cool
	always_ff @(posedge mclk) begin
		if (rst) begin
			ramp_cnt_reg <= 16'h0000;
			boost_reg[0] <= 8'h00;
			boost_reg[1] <= 8'h00;
		end else begin
			ramp_cnt_reg <= (32'(ramp_cnt_reg) + 1 >= RAMP_LEN) ? 16'h0000 : ramp_cnt_reg + 16'h0001;
			if (32'(ramp_cnt_reg) + 1 >= RAMP_LEN) begin
				for (int i = 0; i < 2; i++) begin
					if (hot_s[i] && boost_reg[i] != 8'hFF) begin
						boost_reg[i] <= boost_reg[i] + 8'h01;
					end else if (!hot_s[i] && boost_reg[i] != 8'h00) begin
						boost_reg[i] <= boost_reg[i] - 8'h01;
					end
				end
			end
		end
	end

	// duty from zone temperature or floor, plus the boost, saturated
	always_comb begin
		logic [8:0] sum;
		sum = 9'h000;
		for (int i = 0; i < 2; i++) begin
			sum = {1'b0, (zone_temp > fan_base_reg) ? zone_temp : fan_base_reg}
				+ {1'b0, boost_reg[i]};
			duty[i] = sum[8] ? 8'hFF : sum[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pwm_cnt_reg <= 8'h00;
			fan_drive_1 <= 1'b0;
			fan_drive_2 <= 1'b0;
		end else begin
			pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
			fan_drive_1 <= pwm_cnt_reg < duty[0];
			fan_drive_2 <= pwm_cnt_reg < duty[1];
		end
	end

	// general purpose outputs from the control register
	always_ff @(posedge mclk) begin
		if (rst) begin
			gpio_out <= 8'h00;
			gpio_oe <= 8'h00;
		end else begin
			gpio_out <= gpio_ctl_reg[7:0];
			gpio_oe <= gpio_ctl_reg[15:8];
		end
	end

	// ==========================================================
	// slave address latch; only the fixed upper bits ever match
	logic [1:0] sel_low;
	always_comb begin
		case (addr_sel)
			SEL_HIGH: sel_low = LOW_BITS_HIGH;
			SEL_MID: sel_low = LOW_BITS_MID;
			default: sel_low = LOW_BITS_LOW;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_latched <= 1'b0;
			slave_addr <= 7'h00;
			addr_hit <= 1'b0;
		end else begin
			if (txn_valid && !addr_latched && txn_addr[6:2] == ADDR_UPPER) begin
				addr_latched <= 1'b1;
				slave_addr <= {ADDR_UPPER, sel_low};
			end
			// alert response address never matches the fixed upper bits
			addr_hit <= txn_valid && txn_addr == (addr_latched ? slave_addr
				: {ADDR_UPPER, sel_low});
		end
	end

	// ==========================================================
	// register bus read path
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
			case ({s_axi_araddr[7:2], 2'b00})
				CONFIG_OFS: s_axi_rdata <= config_reg;
				STATUS_OFS: s_axi_rdata <= {15'h0000, reset_s, 1'b0, slave_addr,
					6'h00, addr_latched, error_summary_flag};
				ERROR_OFS: s_axi_rdata <= {16'h0000, err_view};
				MASK_OFS: s_axi_rdata <= {20'h00000, mask_reg};
				GPIO_OFS: s_axi_rdata <= {6'h00, gp_s, gpio_ctl_reg};
				FAN_OFS: s_axi_rdata <= {8'h00, duty[1], duty[0], fan_base_reg};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// address channel open while no read answer will stand
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !(s_axi_arvalid && s_axi_arready)
				&& !(s_axi_rvalid && !s_axi_rready);
		end
	end

	// ==========================================================
	// assertions and covers
	a_alert_never_high: assert property (@(posedge mclk) disable iff (rst)
		alert_n_out == 1'b0) else $error("alert pin drives high");
	a_alert_inverse_flag: assert property (@(posedge mclk) disable iff (rst)
		$past(config_reg[CFG_ALERT_EN]) |-> alert_n_oe == error_summary_flag)
		else $error("alert pin differs from summary flag");
	a_fixed_bits_ignored: assert property (@(posedge mclk) disable iff (rst)
		(err_view & ERR_ALERT_MASK) == '0 |=> !error_summary_flag)
		else $error("summary set by fixed threshold bits");
	a_flag_while_disabled: assert property (@(posedge mclk) disable iff (rst)
		(!config_reg[CFG_ALERT_EN] && |(err_view & ERR_ALERT_MASK))
		|=> error_summary_flag && !alert_n_oe)
		else $error("summary flag not kept with alert disabled");
	a_reenable_alert: assert property (@(posedge mclk) disable iff (rst)
		$rose(config_reg[CFG_ALERT_EN]) && summary |=> alert_n_oe)
		else $error("alert not reasserted on enable");
	a_release_on_disable: assert property (@(posedge mclk) disable iff (rst)
		$fell(config_reg[CFG_ALERT_EN]) |=> !alert_n_oe)
		else $error("alert not released on disable");
	a_thermal_compare: assert property (@(posedge mclk) disable iff (rst)
		(config_reg[CFG_ALERT_EN] && |(thermal_event & ~mask_reg[11:10])) |=> alert_n_oe)
		else $error("thermal event not on alert");
	a_por_drive: assert property (@(posedge mclk) disable iff (rst)
		32'(por_cnt_reg) + 1 < POR_LEN |=> reset_n_oe)
		else $error("reset pin not driven during power-up");
	a_pin_released: assert property (@(posedge mclk) disable iff (rst)
		ext_armed |-> !reset_n_oe) else $error("reset pin driven after power-up");
	a_unlock_sleep: assert property (@(posedge mclk) disable iff (rst)
		(ext_armed && !reset_s) |=> !config_reg[CFG_LOCK]
		&& config_reg[CFG_SLEEP_HI:CFG_SLEEP_LO] == SLEEP_S45)
		else $error("external reset not applied");
	a_throttle_follow: assert property (@(posedge mclk) disable iff (rst)
		(hot_s[0] && awake && !config_reg[CFG_THR_DIS]) |=> processor_throttle_line_oe[0])
		else $error("throttle not asserted on overheat");
	a_mask_no_error: assert property (@(posedge mclk) disable iff (rst)
		(mask_reg[0] && !err_reg[ERR_GP_LO] && !(wr_go && waddr_reg == MASK_OFS))
		|=> !err_reg[ERR_GP_LO])
		else $error("masked input set an error");
	a_addr_kept: assert property (@(posedge mclk) disable iff (rst)
		addr_latched |=> addr_latched && $stable(slave_addr))
		else $error("latched address changed");
	a_addr_map: assert property (@(posedge mclk) disable iff (rst)
		(txn_valid && !addr_latched && txn_addr[6:2] == ADDR_UPPER && addr_sel == SEL_MID)
		|=> slave_addr == 7'h2E) else $error("wrong slave address latched");
	c_alert_seen: cover property (@(posedge mclk) disable iff (rst) $rose(alert_n_oe));
	c_ext_reset: cover property (@(posedge mclk) disable iff (rst) $rose(ext_reset));
	c_addr_latch: cover property (@(posedge mclk) disable iff (rst) $rose(addr_latched));
	c_throttle: cover property (@(posedge mclk) disable iff (rst)
		$rose(processor_throttle_line_oe[1]));
endmodule // alert_reset_address_logic

// ---- sim/smbus_host_model.sv ----
/*
 * management controller model: issues serial transactions and pulls the
 * shared reset pin low on request.
 * assumes the bench resolves the reset wire from this model's pull.
 */
`timescale 1ns/1ps
module smbus_host_model
	import alert_pkg::*;
#(
	parameter int PULSE_LEN = MIN_PULSE_CYCLES + 10
) (
	// clock and bench reset
	input wire logic mclk,
	input wire logic rst,
	// requests from the bench
	input wire logic txn_req,
	input wire logic [6:0] req_addr,
	input wire logic rst_req,
	// toward the device
	output logic txn_valid,
	output logic [6:0] txn_addr,
	output logic pin_low
);
	int cnt;
	// ==========================================
	// transaction strobe; address garbles when idle
	always_ff @(posedge mclk) begin
		if (rst) begin
			txn_valid <= 1'b0;
			txn_addr <= 7'h00;
		end else begin
			txn_valid <= txn_req;
			txn_addr <= txn_req ? req_addr : ~txn_addr;
		end
	end
	// reset pulse held past the shortest legal width
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt <= 0;
		end else if (rst_req) begin
			cnt <= PULSE_LEN;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
	assign pin_low = (cnt != 0);
endmodule // smbus_host_model

// ---- sim/alert_reset_address_logic_tb_top.sv ----
/*
 * self-checking bench: register access, alert, reset pin, overheat,
 * masking and address latching.
 * assumes the design holds its own assertions.
 */
`timescale 1ns/1ps
module alert_reset_address_logic_tb_top;
	import alert_pkg::*;
	localparam int POR_N = 8;
	logic mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awready, s_axi_wready;
	logic s_axi_bready, s_axi_rready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, gpio_in, gpio_out, gpio_oe, gp_drv, zone_temp;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, processor_throttle_line_out, processor_throttle_line_oe;
	logic [1:0] thermal_event, input_only_pin, r;
	logic alert_n_out, alert_n_oe, reset_n_in, reset_n_out, reset_n_oe, addr_latched, addr_hit;
	logic regulator1_overheat_in, regulator2_overheat_in, txn_valid, txn_req, rst_req, pin_low;
	logic [2:0] addr_sel;
	logic [6:0] txn_addr, slave_addr, req_addr;
	logic [6:0] exp_addr [3] = '{7'h2D, 7'h2E, 7'h2C};
	logic [1:0] sel_code [3] = '{SEL_HIGH, SEL_MID, SEL_LOW};
	int error_cnt = 0;
	int tests_run = 0;
	int hi;
	logic hit, fan_drive_1, fan_drive_2;
	// ==========================================
	// clock and open-drain / two-way wires
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	assign reset_n_in = ~(reset_n_oe | pin_low);
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gp_drv);
	alert_reset_address_logic #(.POR_LEN(POR_N), .RAMP_LEN(4)) u_alert_reset_address_logic (
		.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.alert_n_out, .alert_n_oe, .reset_n_in, .reset_n_out, .reset_n_oe, .regulator1_overheat_in,
		.regulator2_overheat_in, .processor_throttle_line_out, .processor_throttle_line_oe,
		.thermal_event, .zone_temp, .fan_drive_1, .fan_drive_2, .gpio_in, .gpio_out, .gpio_oe,
		.input_only_pin, .addr_sel, .txn_valid, .txn_addr, .slave_addr, .addr_latched, .addr_hit);
	smbus_host_model u_smbus_host_model (.mclk, .rst, .txn_req, .req_addr, .rst_req, .txn_valid,
		.txn_addr, .pin_low);
	// ==========================================
	// helpers
	task automatic close_out();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic hang();
		error_cnt++;
		$display("BAD bus wait expected answer seen none");
		close_out();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) hang();
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) hang();
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic send(input logic [6:0] a);
		req_addr <= a;
		txn_req <= 1'b1;
		tick(1);
		txn_req <= 1'b0;
		tick(2);
		hit = addr_hit;
		tick(1);
	endtask
	// ==========================================
	// main sequence
	initial begin
		{rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, txn_req, rst_req} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_addr, gp_drv, zone_temp} = '0;
		{thermal_event, input_only_pin, regulator1_overheat_in, regulator2_overheat_in} = '0;
		addr_sel = SEL_HIGH;
		for (int i = 0; i < 3; i++) begin
			rst <= 1'b1;
			tick(6);
			rst <= 1'b0;
			tick(2);
			chk("por_pull", 1, reset_n_oe);
			tick(POR_N + 6);
			chk("por_free", 0, reset_n_oe);
			addr_sel <= {1'b0, sel_code[i]};
			send(7'h50);
			chk("no_latch", 0, addr_latched);
			send(7'h2C);
			chk("addr", exp_addr[i], slave_addr);
			addr_sel <= {1'b0, sel_code[(i + 1) % 3]};
			send(exp_addr[i]);
			chk("addr_kept", exp_addr[i], slave_addr);
			chk("hit", 1, hit);
			send(7'h0C);
			chk("ara", 0, hit);
		end
		wr(CONFIG_OFS, 32'h1);
		gp_drv <= 8'h01;
		tick(8);
		chk("alert_on", 1, alert_n_oe);
		chk("drive_low", 0, {reset_n_out, processor_throttle_line_out, alert_n_out});
		rd(STATUS_OFS);
		chk("flag", 1, d[0]);
		gp_drv <= 8'h00;
		tick(4);
		wr(ERROR_OFS, 32'h4);
		tick(6);
		chk("alert_off", 0, alert_n_oe);
		input_only_pin <= 2'h1;
		tick(8);
		input_only_pin <= 2'h0;
		wr(CONFIG_OFS, 32'h0);
		tick(2);
		chk("alert_dis", 0, alert_n_oe);
		rd(ERROR_OFS);
		chk("err_gpi", 32'h400, d);
		rd(STATUS_OFS);
		chk("flag_dis", 1, d[0]);
		wr(CONFIG_OFS, 32'h1);
		tick(2);
		chk("alert_reen", 1, alert_n_oe);
		wr(ERROR_OFS, 32'hFFFF);
		wr(MASK_OFS, 32'h1);
		gp_drv <= 8'h01;
		tick(8);
		rd(ERROR_OFS);
		chk("masked", 0, d);
		gp_drv <= 8'h00;
		thermal_event <= 2'h2;
		tick(4);
		chk("therm_on", 1, alert_n_oe);
		thermal_event <= 2'h0;
		tick(3);
		chk("therm_off", 0, alert_n_oe);
		{regulator1_overheat_in, regulator2_overheat_in} <= 2'b11;
		tick(6);
		chk("throttle", 2'h3, processor_throttle_line_oe);
		rd(ERROR_OFS);
		chk("hot_err", 32'h3, d);
		{regulator1_overheat_in, regulator2_overheat_in} <= 2'b00;
		tick(6);
		chk("throttle_off", 0, processor_throttle_line_oe);
		wr(ERROR_OFS, 32'hFFFF);
		wr(CONFIG_OFS, 32'h3);
		wr(MASK_OFS, 32'h0);
		rd(MASK_OFS);
		chk("locked", 1, d);
		rst_req <= 1'b1;
		tick(1);
		rst_req <= 1'b0;
		tick(300);
		rd(CONFIG_OFS);
		chk("ext_reset", 32'h21, d);
		regulator1_overheat_in <= 1'b1;
		tick(6);
		chk("sleep_thr", 0, processor_throttle_line_oe);
		regulator1_overheat_in <= 1'b0;
		tick(200);
		rd(8'h40);
		chk("bad_rd", {30'h0, RESP_SLVERR}, {d[29:0], r});
		wr(8'h40, 32'h1);
		chk("bad_wr", RESP_SLVERR, r);
		wr(GPIO_OFS, 32'hFF5A);
		tick(3);
		chk("gpio", 16'hFF5A, {gpio_oe, gpio_out});
		wr(FAN_OFS, 32'h80);
		tick(2);
		hi = 0;
		repeat (256) begin
			@(posedge mclk);
			hi += fan_drive_1 + fan_drive_2;
		end
		chk("fan_duty", 256, hi);
		close_out();
	end
endmodule // alert_reset_address_logic_tb_top
